// >>> hw/acorr_pkg.sv
`default_nettype none
package acorr_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 24;
    localparam int AMP_W = 3;
    localparam int GAIN_FRAC = 22;

    // Register byte offsets
    localparam logic [ADDR_W-1:0] OFS_ADDR = 8'h00;
    localparam logic [ADDR_W-1:0] GAIN_ADDR = 8'h04;
    localparam logic [ADDR_W-1:0] AMP_ADDR = 8'h08;
    localparam logic [ADDR_W-1:0] RESULT_ADDR = 8'h0C;
    localparam logic [ADDR_W-1:0] TRIM_ADDR = 8'h10;

    // Field positions
    localparam int CLIP_BIT = 24;
    localparam int TRIM_IDX_LSB = 24;

    // Reset values and codes
    localparam logic [23:0] OFS_RESET = 24'h000000;
    localparam logic [23:0] GAIN_UNITY = 24'h400000;
    localparam logic [2:0] AMP_RESET = 3'h0;
    localparam logic [23:0] CODE_MAX = 24'h7FFFFF;
    localparam logic [23:0] CODE_MIN = 24'h800000;
    localparam logic signed [49:0] SAT_HI = 50'sh7FFFFF;
    localparam logic signed [49:0] SAT_LO = -50'sh800000;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {
        WR_COLLECT = 2'h0,
        WR_COMMIT = 2'h1,
        WR_RESP = 2'h3
    } acorr_wr_e;

    // Raw word minus offset, both signed, one bit wider so nothing wraps
    function automatic logic signed [24:0] acorr_sub(
        input logic [23:0] raw,
        input logic [23:0] ofs
    );
        acorr_sub = $signed({raw[23], raw}) - $signed({ofs[23], ofs});
    endfunction : acorr_sub

    // Scale by gain/2^22 and saturate; bit 24 flags a clip
    function automatic logic [24:0] acorr_scale(
        input logic signed [24:0] diff,
        input logic [23:0] gain
    );
        logic signed [49:0] prod;
        logic signed [49:0] q;
        prod = diff * $signed({1'b0, gain});
        q = prod >>> GAIN_FRAC;
        if (q > SAT_HI) begin
            acorr_scale = {1'b1, CODE_MAX};
        end else if (q < SAT_LO) begin
            acorr_scale = {1'b1, CODE_MIN};
        end else begin
            acorr_scale = {1'b0, q[23:0]};
        end
    endfunction : acorr_scale

    // Byte-lane merge for the 24-bit correction words
    function automatic logic [23:0] acorr_merge(
        input logic [23:0] old,
        input logic [31:0] wdata,
        input logic [3:0] strb
    );
        logic [23:0] r;
        r = old;
        for (int i = 0; i < 3; i++) begin
            if (strb[i]) begin
                r[i*8 +: 8] = wdata[i*8 +: 8];
            end
        end
        acorr_merge = r;
    endfunction : acorr_merge
endpackage : acorr_pkg
`default_nettype wire

// >>> hw/acorr_trim_mem.sv
`timescale 1ns/1ps
`default_nettype none
module acorr_trim_mem #(
    parameter int WIDTH = 24,
    parameter int DEPTH = 8,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Write port
    input wire logic we_i,
    input wire logic [$clog2(DEPTH)-1:0] waddr_i,
    input wire logic [WIDTH-1:0] wdata_i,
    // Registered read port
    input wire logic [$clog2(DEPTH)-1:0] raddr_i,
    output logic [WIDTH-1:0] rdata_o
);
    generate
        if (DEPTH < 2 || WIDTH < 1) begin : g_bad
            $error("acorr_trim_mem: DEPTH must be >= 2, WIDTH >= 1");
        end
    endgenerate

    logic [WIDTH-1:0] mem [DEPTH];

    // Every entry starts at the default so a reload before any trim is safe
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            for (int i = 0; i < DEPTH; i++) begin
                mem[i] <= INIT;
            end
            rdata_o <= INIT;
        end else begin
            if (we_i) begin
                mem[waddr_i] <= wdata_i;
            end
            rdata_o <= mem[raddr_i];
        end
    end
endmodule : acorr_trim_mem
`default_nettype wire

// >>> hw/acorr_core.sv
// Implementation choices: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Operation
// - Output equals (filter word minus offset word) times gain word over 400000h.
// - Corrected result is clipped to 24 bits and never wraps.
// - Offset word is 24-bit two's complement held as three byte lanes.
// - Offset word spans 7FFFFFh down to 800000h, plus or minus full scale.
// - Offset word 000000h leaves the conversion data unchanged.
// - Both words load by host write or by calibration completion.
// - Zero input gives FFFFFFh with offset 000001h, 000000h with offset zero.
// - Gain word is 24-bit unsigned in three bytes; 400000h means unity.
// - Amplifier gain change reloads the gain word from its trimmed default.
module acorr_core (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // AXI4-Lite write address and data
    input wire logic [acorr_pkg::ADDR_W-1:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    // AXI4-Lite read
    input wire logic [acorr_pkg::ADDR_W-1:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    // Decimation filter stream
    input wire logic [23:0] filt_data_i,
    input wire logic filt_valid_i,
    // Calibration engine loads
    input wire logic cal_ofs_load_i,
    input wire logic [23:0] cal_ofs_i,
    input wire logic cal_gain_load_i,
    input wire logic [23:0] cal_gain_i,
    // Corrected stream to the result register
    output logic [23:0] corr_data_o,
    output logic corr_valid_o,
    output logic corr_clip_o,
    // Amplifier gain setting to the analog front end
    output logic [acorr_pkg::AMP_W-1:0] input_amplifier_gain_o
);
    typedef struct packed {
        acorr_pkg::acorr_wr_e wr;
        logic awready;
        logic wready;
        logic aw_got;
        logic w_got;
        logic [acorr_pkg::ADDR_W-1:0] awaddr;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [23:0] offset_correction_word;
        logic [23:0] gain_correction_word;
        logic [acorr_pkg::AMP_W-1:0] input_amplifier_gain;
        logic [1:0] reload;
        logic trim_we;
        logic [acorr_pkg::AMP_W-1:0] trim_waddr;
        logic [23:0] trim_wdata;
        logic s1_valid;
        logic [24:0] s1_diff;
        logic [23:0] s1_gain;
        logic out_valid;
        logic [23:0] result;
        logic clip;
    } acorr_state_s;

    localparam acorr_state_s ST_RESET = '{
        wr: acorr_pkg::WR_COLLECT,
        offset_correction_word: acorr_pkg::OFS_RESET,
        gain_correction_word: acorr_pkg::GAIN_UNITY,
        input_amplifier_gain: acorr_pkg::AMP_RESET,
        default: '0
    };

    acorr_state_s st;
    acorr_state_s next_st;
    logic [23:0] trim_rdata;
    logic amp_change;

    // Trimmed gain defaults, one per amplifier setting
    acorr_trim_mem #(
        .WIDTH(24),
        .DEPTH(1 << acorr_pkg::AMP_W),
        .INIT(acorr_pkg::GAIN_UNITY)
    ) u_trim (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .we_i(st.trim_we),
        .waddr_i(st.trim_waddr),
        .wdata_i(st.trim_wdata),
        .raddr_i(st.input_amplifier_gain),
        .rdata_o(trim_rdata)
    );

    assign amp_change = (st.wr == acorr_pkg::WR_COMMIT) &&
        (st.awaddr == acorr_pkg::AMP_ADDR) && st.wstrb[0] &&
        (st.wdata[acorr_pkg::AMP_W-1:0] != st.input_amplifier_gain);

    always_comb begin
        next_st = st;
        next_st.trim_we = 1'b0;
        next_st.reload = {st.reload[0], 1'b0};
        // Address and data may arrive in either order
        if (s_axi_awvalid_i && st.awready) begin
            next_st.awaddr = s_axi_awaddr_i;
            next_st.aw_got = 1'b1;
        end
        if (s_axi_wvalid_i && st.wready) begin
            next_st.wdata = s_axi_wdata_i;
            next_st.wstrb = s_axi_wstrb_i;
            next_st.w_got = 1'b1;
        end
        unique case (st.wr)
            acorr_pkg::WR_COLLECT: begin
                if (st.aw_got && st.w_got) begin
                    next_st.wr = acorr_pkg::WR_COMMIT;
                end
            end
            acorr_pkg::WR_COMMIT: begin
                next_st.aw_got = 1'b0;
                next_st.w_got = 1'b0;
                next_st.bvalid = 1'b1;
                next_st.bresp = acorr_pkg::RESP_OKAY;
                next_st.wr = acorr_pkg::WR_RESP;
                if (st.awaddr == acorr_pkg::OFS_ADDR) begin
                    next_st.offset_correction_word = acorr_pkg::acorr_merge(
                        st.offset_correction_word, st.wdata,
                        st.wstrb);
                end else if (st.awaddr == acorr_pkg::GAIN_ADDR) begin
                    next_st.gain_correction_word = acorr_pkg::acorr_merge(
                        st.gain_correction_word, st.wdata,
                        st.wstrb);
                end else if (st.awaddr == acorr_pkg::AMP_ADDR) begin
                    if (st.wstrb[0]) begin
                        next_st.input_amplifier_gain =
                            st.wdata[acorr_pkg::AMP_W-1:0];
                    end
                    next_st.reload[0] = amp_change;
                end else if (st.awaddr == acorr_pkg::TRIM_ADDR) begin
                    next_st.trim_we = 1'b1;
                    next_st.trim_waddr = st.wdata[acorr_pkg::TRIM_IDX_LSB +:
                        acorr_pkg::AMP_W];
                    next_st.trim_wdata = st.wdata[23:0];
                end else if (st.awaddr != acorr_pkg::RESULT_ADDR) begin
                    next_st.bresp = acorr_pkg::RESP_SLVERR;
                end
            end
            acorr_pkg::WR_RESP: begin
                if (s_axi_bready_i) begin
                    next_st.bvalid = 1'b0;
                    next_st.wr = acorr_pkg::WR_COLLECT;
                end
            end
            default: begin
                next_st.wr = acorr_pkg::WR_COLLECT;
            end
        endcase
        next_st.awready = !next_st.aw_got &&
            (next_st.wr == acorr_pkg::WR_COLLECT);
        next_st.wready = !next_st.w_got &&
            (next_st.wr == acorr_pkg::WR_COLLECT);

        // Calibration results win over a host write in the same cycle
        if (cal_ofs_load_i) begin
            next_st.offset_correction_word = cal_ofs_i;
        end
        if (cal_gain_load_i) begin
            next_st.gain_correction_word = cal_gain_i;
        end
        // The trimmed default follows the newest amplifier setting
        if (st.reload[1]) begin
            next_st.gain_correction_word = trim_rdata;
        end

        if (s_axi_arvalid_i && st.arready) begin
            next_st.rvalid = 1'b1;
            next_st.rresp = acorr_pkg::RESP_OKAY;
            next_st.rdata = '0;
            if (s_axi_araddr_i == acorr_pkg::OFS_ADDR) begin
                next_st.rdata[23:0] = st.offset_correction_word;
            end else if (s_axi_araddr_i == acorr_pkg::GAIN_ADDR) begin
                next_st.rdata[23:0] = st.gain_correction_word;
            end else if (s_axi_araddr_i == acorr_pkg::AMP_ADDR) begin
                next_st.rdata[acorr_pkg::AMP_W-1:0] =
                    st.input_amplifier_gain;
            end else if (s_axi_araddr_i == acorr_pkg::RESULT_ADDR) begin
                next_st.rdata[23:0] = st.result;
                next_st.rdata[acorr_pkg::CLIP_BIT] = st.clip;
            end else if (s_axi_araddr_i != acorr_pkg::TRIM_ADDR) begin
                next_st.rresp = acorr_pkg::RESP_SLVERR;
            end
        end else if (st.rvalid && s_axi_rready_i) begin
            next_st.rvalid = 1'b0;
        end
        next_st.arready = !next_st.rvalid;

        // Two stages: subtract, then scale and clip, to split the long path
        next_st.s1_valid = filt_valid_i;
        if (filt_valid_i) begin
            next_st.s1_diff = acorr_pkg::acorr_sub(filt_data_i,
                st.offset_correction_word);
            next_st.s1_gain = st.gain_correction_word;
        end
        next_st.out_valid = st.s1_valid;
        if (st.s1_valid) begin
            {next_st.clip, next_st.result} = acorr_pkg::acorr_scale(
                st.s1_diff, st.s1_gain);
        end
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= ST_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign s_axi_awready_o = st.awready;
    assign s_axi_wready_o = st.wready;
    assign s_axi_bvalid_o = st.bvalid;
    assign s_axi_bresp_o = st.bresp;
    assign s_axi_arready_o = st.arready;
    assign s_axi_rvalid_o = st.rvalid;
    assign s_axi_rdata_o = st.rdata;
    assign s_axi_rresp_o = st.rresp;
    assign corr_data_o = st.result;
    assign corr_valid_o = st.out_valid;
    assign corr_clip_o = st.clip;
    assign input_amplifier_gain_o = st.input_amplifier_gain;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    property p_formula;
        filt_valid_i |-> ##2 (st.out_valid && ({st.clip, st.result} ==
            acorr_pkg::acorr_scale(acorr_pkg::acorr_sub($past(filt_data_i, 2),
            $past(st.offset_correction_word, 2)),
            $past(st.gain_correction_word, 2))));
    endproperty
    a_formula: assert property (p_formula)
        else $error("corrected word does not match formula");

    property p_sat;
        st.out_valid && st.clip |->
            (st.result == acorr_pkg::CODE_MAX) ||
            (st.result == acorr_pkg::CODE_MIN);
    endproperty
    a_sat: assert property (p_sat)
        else $error("clipped result is not a limit code");

    property p_neg_sat;
        filt_valid_i && (filt_data_i == acorr_pkg::CODE_MIN) &&
        (st.offset_correction_word == acorr_pkg::CODE_MAX) &&
        (st.gain_correction_word == acorr_pkg::GAIN_UNITY) |->
            ##2 (st.clip && (st.result == acorr_pkg::CODE_MIN));
    endproperty
    a_neg_sat: assert property (p_neg_sat)
        else $error("negative overflow not held at lowest code");

    property p_ofs_write;
        (st.wr == acorr_pkg::WR_COMMIT) &&
        (st.awaddr == acorr_pkg::OFS_ADDR) && (st.wstrb == 4'hF) &&
        !cal_ofs_load_i |=>
            (st.offset_correction_word == $past(st.wdata[23:0]));
    endproperty
    a_ofs_write: assert property (p_ofs_write)
        else $error("offset word not updated by host write");

    property p_ofs_range;
        filt_valid_i && (filt_data_i == 24'h000000) &&
        (st.offset_correction_word == acorr_pkg::CODE_MIN) &&
        (st.gain_correction_word == acorr_pkg::GAIN_UNITY) |->
            ##2 (st.clip && (st.result == acorr_pkg::CODE_MAX));
    endproperty
    a_ofs_range: assert property (p_ofs_range)
        else $error("most negative offset not corrected to top code");

    property p_no_change;
        filt_valid_i && (st.offset_correction_word == acorr_pkg::OFS_RESET)
        && (st.gain_correction_word == acorr_pkg::GAIN_UNITY) |->
            ##2 (!st.clip && (st.result == $past(filt_data_i, 2)));
    endproperty
    a_no_change: assert property (p_no_change)
        else $error("zero offset and unity gain altered the data");

    property p_one_lsb;
        filt_valid_i && (filt_data_i == 24'h000000) &&
        (st.offset_correction_word == 24'h000001) &&
        (st.gain_correction_word == acorr_pkg::GAIN_UNITY) |->
            ##2 (st.result == 24'hFFFFFF);
    endproperty
    a_one_lsb: assert property (p_one_lsb)
        else $error("offset of one did not give all-ones code");

    property p_cal_ofs;
        cal_ofs_load_i |=> (st.offset_correction_word == $past(cal_ofs_i));
    endproperty
    a_cal_ofs: assert property (p_cal_ofs)
        else $error("calibration offset not loaded");

    property p_cal_gain;
        cal_gain_load_i && !st.reload[1] |=>
            (st.gain_correction_word == $past(cal_gain_i));
    endproperty
    a_cal_gain: assert property (p_cal_gain)
        else $error("calibration gain not loaded");

    property p_reload;
        amp_change |-> ##2 st.reload[1] ##1
            (st.gain_correction_word == $past(trim_rdata));
    endproperty
    a_reload: assert property (p_reload)
        else $error("gain word not reloaded after amplifier change");

    c_clip: cover property (st.out_valid && st.clip);
    c_reload: cover property (st.reload[1]);
    c_write: cover property (st.bvalid && s_axi_bready_i);
    c_read: cover property (st.rvalid && s_axi_rready_i);
endmodule : acorr_core
`default_nettype wire

// >>> testbench/acorr_filt_model.sv
`timescale 1ns/1ps
`default_nettype none
module acorr_filt_model (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Filter words toward the correction stage
    output logic [23:0] filt_data_o,
    output logic filt_valid_o,
    // Corrected words into the result register
    input wire logic [23:0] corr_data_i,
    input wire logic corr_valid_i,
    input wire logic corr_clip_i
);
    logic [23:0] pend[$];
    logic [24:0] got[$];
    int gap = 0;
    int idle = 0;

    // Idle cycles put the inverse word on the bus so stale data never matches
    always @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            filt_valid_o <= 1'b0;
            filt_data_o <= 24'h000000;
            idle = 0;
        end else begin
            if (corr_valid_i === 1'b1) begin
                got.push_back({corr_clip_i, corr_data_i});
            end
            if (pend.size() != 0 && idle >= gap) begin
                filt_data_o <= pend.pop_front();
                filt_valid_o <= 1'b1;
                idle = 0;
            end else begin
                filt_data_o <= ~filt_data_o;
                filt_valid_o <= 1'b0;
                idle++;
            end
        end
    end
endmodule : acorr_filt_model
`default_nettype wire

// >>> testbench/acorr_core_tb.sv
`timescale 1ns/1ps
`default_nettype none
module acorr_core_tb;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic arvalid = 1'b0, rready = 1'b0;
    logic [31:0] wdata = 32'h00000000;
    logic [3:0] wstrb = 4'h0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [23:0] filt_data, corr_data, cal_ofs = 24'h0, cal_gain = 24'h0;
    logic filt_valid, corr_valid, corr_clip;
    logic cal_ofs_load = 1'b0, cal_gain_load = 1'b0;
    logic [2:0] amp;
    logic [23:0] raws[$];
    logic [24:0] last_exp;
    int bad_count = 0, check_count = 0, cycles = 0;

    acorr_core i_dut (.clk_i(clk_i), .rst_i(rst_i),
        .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
        .s_axi_awready_o(awready), .s_axi_wdata_i(wdata),
        .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
        .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
        .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready),
        .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
        .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
        .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid),
        .s_axi_rready_i(rready), .filt_data_i(filt_data),
        .filt_valid_i(filt_valid), .cal_ofs_load_i(cal_ofs_load),
        .cal_ofs_i(cal_ofs), .cal_gain_load_i(cal_gain_load),
        .cal_gain_i(cal_gain), .corr_data_o(corr_data),
        .corr_valid_o(corr_valid), .corr_clip_o(corr_clip),
        .input_amplifier_gain_o(amp));

    acorr_filt_model i_filt (.clk_i(clk_i), .rst_i(rst_i),
        .filt_data_o(filt_data), .filt_valid_o(filt_valid),
        .corr_data_i(corr_data), .corr_valid_i(corr_valid),
        .corr_clip_i(corr_clip));

    initial begin
        forever #4 clk_i = ~clk_i;
    end

    task automatic tally_and_finish();
        if (bad_count == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : tally_and_finish

    // Generous ceiling: the whole sequence needs little more than a thousand cycles
    always @(posedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            tally_and_finish();
        end
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // Floor scaling, as a signed shift of the exact product
    function automatic logic [24:0] exp_corr(input logic [23:0] raw,
            input logic [23:0] ofs, input logic [23:0] gain);
        longint d;
        longint q;
        d = longint'($signed(raw)) - longint'($signed(ofs));
        q = (d * longint'({40'h0, gain})) >>> 22;
        if (q > 64'sh7FFFFF) begin
            return {1'b1, 24'h7FFFFF};
        end
        if (q < -64'sh800000) begin
            return {1'b1, 24'h800000};
        end
        return {1'b0, q[23:0]};
    endfunction : exp_corr

    // Ready is read before the edge's updates land, i.e. as sampled
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d,
            input logic [3:0] s, output logic [1:0] r);
        @(posedge clk_i);
        awaddr <= a;
        awvalid <= 1'b1;
        wdata <= d;
        wstrb <= s;
        wvalid <= 1'b1;
        bready <= 1'b1;
        fork
            begin
                do @(posedge clk_i); while (awready !== 1'b1);
                awvalid <= 1'b0;
            end
            begin
                do @(posedge clk_i); while (wready !== 1'b1);
                wvalid <= 1'b0;
            end
        join
        do @(posedge clk_i); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask : axi_wr

    task automatic axi_rd(input logic [7:0] a, output logic [31:0] d,
            output logic [1:0] r);
        @(posedge clk_i);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clk_i); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge clk_i); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask : axi_rd

    task automatic run_words(input logic [23:0] ofs, input logic [23:0] gain);
        int n;
        n = raws.size();
        foreach (raws[i]) i_filt.pend.push_back(raws[i]);
        repeat (n * 4 + 8) @(posedge clk_i);
        check(i_filt.got.size(), n);
        foreach (raws[i]) begin
            last_exp = exp_corr(raws[i], ofs, gain);
            check(i_filt.got[i], last_exp);
        end
        i_filt.got.delete();
        raws.delete();
    endtask : run_words

    initial begin
        logic [31:0] d;
        logic [1:0] r;
        logic [23:0] o;
        logic [23:0] g;
        logic [23:0] tbl[5];
        tbl = '{24'h7FFFFF, 24'h000001, 24'h000000, 24'hFFFFFF, 24'h800000};
        void'($urandom(32'hAE78C847));
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        axi_rd(acorr_pkg::OFS_ADDR, d, r);
        check(d, 32'h00000000);
        axi_rd(acorr_pkg::GAIN_ADDR, d, r);
        check(d, 32'h00400000);
        axi_rd(8'h14, d, r);
        check(r, acorr_pkg::RESP_SLVERR);
        axi_wr(8'h18, 32'h00000001, 4'hF, r);
        check(r, acorr_pkg::RESP_SLVERR);
        foreach (tbl[i]) begin
            axi_wr(acorr_pkg::OFS_ADDR, {8'h00, tbl[i]}, 4'hF, r);
            raws.push_back(24'h000000);
            raws.push_back(24'h800000);
            run_words(tbl[i], 24'h400000);
        end
        axi_wr(acorr_pkg::OFS_ADDR, 32'hAABBCCDD, 4'h2, r);
        axi_rd(acorr_pkg::OFS_ADDR, d, r);
        check(d, 32'h0080CC00);
        @(posedge clk_i);
        cal_ofs <= 24'h123456;
        cal_ofs_load <= 1'b1;
        cal_gain <= 24'h654321;
        cal_gain_load <= 1'b1;
        @(posedge clk_i);
        cal_ofs_load <= 1'b0;
        cal_gain_load <= 1'b0;
        axi_rd(acorr_pkg::OFS_ADDR, d, r);
        check(d, 32'h00123456);
        axi_rd(acorr_pkg::GAIN_ADDR, d, r);
        check(d, 32'h00654321);
        axi_wr(acorr_pkg::TRIM_ADDR, 32'h052ABCDE, 4'hF, r);
        check(r, acorr_pkg::RESP_OKAY);
        axi_rd(acorr_pkg::TRIM_ADDR, d, r);
        check(r, acorr_pkg::RESP_OKAY);
        check(d, 32'h00000000);
        axi_wr(acorr_pkg::AMP_ADDR, 32'h00000005, 4'h1, r);
        check(r, acorr_pkg::RESP_OKAY);
        repeat (4) @(posedge clk_i);
        check(amp, 3'h5);
        axi_rd(acorr_pkg::GAIN_ADDR, d, r);
        check(d, 32'h002ABCDE);
        raws.push_back(24'h3A0000);
        run_words(24'h123456, 24'h2ABCDE);
        repeat (24) begin
            o = 24'($urandom);
            g = 24'($urandom);
            if ($urandom_range(3) == 0) begin
                g = 24'hFFFFFF;
            end
            i_filt.gap = $urandom_range(2);
            axi_wr(acorr_pkg::OFS_ADDR, {8'h00, o}, 4'h7, r);
            axi_wr(acorr_pkg::GAIN_ADDR, {8'h00, g}, 4'h7, r);
            raws = {24'h7FFFFF, 24'h800000};
            repeat (3) raws.push_back(24'($urandom));
            run_words(o, g);
        end
        axi_rd(acorr_pkg::RESULT_ADDR, d, r);
        check(d, {7'h00, last_exp});
        tally_and_finish();
    end
endmodule : acorr_core_tb
`default_nettype wire
